/* File: design/uhst_channel.sv */
// Purpose: One UART channel with host strobes and ready/interrupt outputs.
// Assumes: Host strobes, write data and the serial input are asynchronous.
// Notes:   Mode and divisor are plain inputs; there is no register file.
//
// Functional notes
// - Non-FIFO data valid within one baud tick
// - Baud tick runs at sixteen times bit rate
// - FIFO mode data readable with status
// - Receive ready set within one clock of stop
// - Transmit ready drops within one bit of start
// - Start bit 8 to 24 bits after clear
// - Receive interrupt within one tick of stop
`default_nettype none

module uhst_channel
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Configuration
    input  wire logic        fifo_mode_i,
    input  wire logic [15:0] baud_divisor_i,
    // Host port
    input  wire logic        host_read_strobe_n_i,
    input  wire logic        host_write_strobe_n_i,
    input  wire logic [7:0]  host_wdata_i,
    output logic      [7:0]  rx_holding_reg_o,
    // Status pins
    output logic             rx_ready_out_o,
    output logic             tx_ready_out_o,
    output logic             irq_o,
    // Serial line
    input  wire logic        rx_i,
    output logic             tx_o
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rd_meta_q;
    logic [1:0] wr_meta_q;
    logic [1:0] rx_meta_q;
    logic [7:0] wd_meta_q;
    logic [7:0] wd_sync_q;
    logic       rd_prev_q;
    logic       wr_prev_q;
    logic       rd_evt;
    logic       wr_evt;
    logic       rx_s;
    logic       tick;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_meta_q <= 2'h3;
            wr_meta_q <= 2'h3;
            rx_meta_q <= 2'h3;
            wd_meta_q <= uhst_pkg::DATA_RESET;
            wd_sync_q <= uhst_pkg::DATA_RESET;
            rd_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
        end
        else
        begin
            rd_meta_q <= {rd_meta_q[0], host_read_strobe_n_i};
            wr_meta_q <= {wr_meta_q[0], host_write_strobe_n_i};
            rx_meta_q <= {rx_meta_q[0], rx_i};
            wd_meta_q <= host_wdata_i;
            wd_sync_q <= wd_meta_q;
            rd_prev_q <= rd_meta_q[1];
            wr_prev_q <= wr_meta_q[1];
        end
    end

    // A read acts when the strobe falls; a write when it rises, so the
    // data has had the whole strobe width to settle through its stages.
    assign rd_evt = rd_prev_q & ~rd_meta_q[1];
    assign wr_evt = ~wr_prev_q & wr_meta_q[1];
    assign rx_s   = rx_meta_q[1];

    uhst_baud_gen u_baud
    (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .divisor_i (baud_divisor_i),
        .tick_o    (tick)
    );

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    uhst_pkg::uhst_rx_state_t rx_st_q, rx_st_d;
    logic [3:0] rx_tk_q, rx_tk_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [7:0] rhr_q, rhr_d;
    logic       rx_pend_q, rx_pend_d;
    logic       rx_rdy_q, rx_rdy_d;
    logic       rx_irq_q, rx_irq_d;

    always_comb
    begin
        rx_st_d   = rx_st_q;
        rx_tk_d   = rx_tk_q;
        rx_bit_d  = rx_bit_q;
        rx_sh_d   = rx_sh_q;
        rhr_d     = rhr_q;
        rx_pend_d = rx_pend_q;
        rx_rdy_d  = rx_rdy_q;
        rx_irq_d  = rx_irq_q;
        if (rd_evt)
        begin
            rx_rdy_d = 1'b0;
            rx_irq_d = 1'b0;
        end
        if (tick)
        begin
            // Single-byte mode loads the holding location one tick after
            // status, which is why the host must hold off that long.
            if (rx_pend_q)
            begin
                rhr_d     = rx_sh_q;
                rx_pend_d = 1'b0;
            end
            rx_tk_d = rx_tk_q + 4'h1;
            case (rx_st_q)
                uhst_pkg::UHST_RX_IDLE:
                begin
                    rx_tk_d = 4'h0;
                    if (!rx_s)
                        rx_st_d = uhst_pkg::UHST_RX_START;
                end
                uhst_pkg::UHST_RX_START:
                begin
                    if (rx_tk_q == uhst_pkg::TICK_MID)
                    begin
                        rx_tk_d  = 4'h0;
                        rx_bit_d = 3'h0;
                        // A glitch shorter than half a bit is rejected.
                        rx_st_d  = rx_s ? uhst_pkg::UHST_RX_IDLE
                                        : uhst_pkg::UHST_RX_DATA;
                    end
                end
                uhst_pkg::UHST_RX_DATA:
                begin
                    if (rx_tk_q == uhst_pkg::TICK_LAST)
                    begin
                        rx_sh_d  = {rx_s, rx_sh_q[7:1]};
                        rx_bit_d = rx_bit_q + 3'h1;
                        if (rx_bit_q == uhst_pkg::BIT_LAST)
                            rx_st_d = uhst_pkg::UHST_RX_STOP;
                    end
                end
                uhst_pkg::UHST_RX_STOP:
                begin
                    if (rx_tk_q == uhst_pkg::TICK_LAST)
                    begin
                        rx_st_d = uhst_pkg::UHST_RX_IDLE;
                        if (rx_s)
                        begin
                            rx_rdy_d = 1'b1;
                            rx_irq_d = 1'b1;
                            if (fifo_mode_i)
                                rhr_d = rx_sh_q;
                            else
                                rx_pend_d = 1'b1;
                        end
                    end
                end
                default:
                    rx_st_d = uhst_pkg::UHST_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rx_st_q   <= uhst_pkg::UHST_RX_IDLE;
            rx_tk_q   <= 4'h0;
            rx_bit_q  <= 3'h0;
            rx_sh_q   <= uhst_pkg::DATA_RESET;
            rhr_q     <= uhst_pkg::DATA_RESET;
            rx_pend_q <= 1'b0;
            rx_rdy_q  <= 1'b0;
            rx_irq_q  <= 1'b0;
        end
        else
        begin
            rx_st_q   <= rx_st_d;
            rx_tk_q   <= rx_tk_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            rhr_q     <= rhr_d;
            rx_pend_q <= rx_pend_d;
            rx_rdy_q  <= rx_rdy_d;
            rx_irq_q  <= rx_irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    uhst_pkg::uhst_tx_state_t tx_st_q, tx_st_d;
    logic [7:0] tx_tk_q, tx_tk_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic [7:0] thr_q, thr_d;
    logic [7:0] tsr_q, tsr_d;
    logic       thr_full_q, thr_full_d;
    logic       tx_irq_q, tx_irq_d;
    logic       tx_rdy_q, tx_rdy_d;
    logic       tx_q, tx_d;

    always_comb
    begin
        tx_st_d    = tx_st_q;
        tx_tk_d    = tx_tk_q;
        tx_bit_d   = tx_bit_q;
        thr_d      = thr_q;
        tsr_d      = tsr_q;
        thr_full_d = thr_full_q;
        tx_irq_d   = tx_irq_q;
        tx_rdy_d   = tx_rdy_q;
        tx_d       = tx_q;
        // A write while a character is held is dropped, not overwritten.
        if (wr_evt && !thr_full_q)
        begin
            thr_d      = wd_sync_q;
            thr_full_d = 1'b1;
            tx_irq_d   = 1'b0;
        end
        if (tick)
        begin
            tx_tk_d = tx_tk_q + 8'h01;
            case (tx_st_q)
                uhst_pkg::UHST_TX_IDLE:
                begin
                    tx_tk_d = 8'h00;
                    if (thr_full_q)
                        tx_st_d = uhst_pkg::UHST_TX_GAP;
                end
                uhst_pkg::UHST_TX_GAP:
                begin
                    if (tx_tk_q == uhst_pkg::TX_GAP_TICKS)
                    begin
                        tx_st_d    = uhst_pkg::UHST_TX_START;
                        tx_tk_d    = 8'h00;
                        tx_d       = 1'b0;
                        tsr_d      = thr_q;
                        thr_full_d = 1'b0;
                        tx_irq_d   = 1'b1;
                        tx_rdy_d   = 1'b0;
                    end
                end
                uhst_pkg::UHST_TX_START,
                uhst_pkg::UHST_TX_DATA:
                begin
                    if (tx_tk_q[3:0] == uhst_pkg::TICK_LAST)
                    begin
                        tx_tk_d = 8'h00;
                        tx_d    = tsr_q[0];
                        tsr_d   = {1'b0, tsr_q[7:1]};
                        if (tx_st_q == uhst_pkg::UHST_TX_START)
                        begin
                            tx_st_d  = uhst_pkg::UHST_TX_DATA;
                            tx_bit_d = 3'h0;
                        end
                        else
                        begin
                            tx_bit_d = tx_bit_q + 3'h1;
                            if (tx_bit_q == uhst_pkg::BIT_LAST)
                            begin
                                tx_st_d = uhst_pkg::UHST_TX_STOP;
                                tx_d    = uhst_pkg::LINE_IDLE;
                            end
                        end
                    end
                end
                uhst_pkg::UHST_TX_STOP:
                begin
                    if (tx_tk_q[3:0] == uhst_pkg::TICK_LAST)
                    begin
                        tx_st_d  = uhst_pkg::UHST_TX_IDLE;
                        tx_rdy_d = 1'b1;
                    end
                end
                default:
                    tx_st_d = uhst_pkg::UHST_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            tx_st_q    <= uhst_pkg::UHST_TX_IDLE;
            tx_tk_q    <= 8'h00;
            tx_bit_q   <= 3'h0;
            thr_q      <= uhst_pkg::DATA_RESET;
            tsr_q      <= uhst_pkg::DATA_RESET;
            thr_full_q <= 1'b0;
            tx_irq_q   <= 1'b1;
            tx_rdy_q   <= 1'b1;
            tx_q       <= uhst_pkg::LINE_IDLE;
        end
        else
        begin
            tx_st_q    <= tx_st_d;
            tx_tk_q    <= tx_tk_d;
            tx_bit_q   <= tx_bit_d;
            thr_q      <= thr_d;
            tsr_q      <= tsr_d;
            thr_full_q <= thr_full_d;
            tx_irq_q   <= tx_irq_d;
            tx_rdy_q   <= tx_rdy_d;
            tx_q       <= tx_d;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic irq_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_q <= 1'b0;
        else
            irq_q <= rx_irq_d | tx_irq_d;
    end

    assign rx_holding_reg_o = rhr_q;
    assign rx_ready_out_o   = rx_rdy_q;
    assign tx_ready_out_o   = tx_rdy_q;
    assign irq_o            = irq_q;
    assign tx_o             = tx_q;

endmodule : uhst_channel

`default_nettype wire

/* File: design/uhst_pkg.sv */
// Purpose: Shared constants for the single-channel host-status UART.
// Assumes: 8 data bits, no parity, one stop bit; 16 baud ticks per bit.
// Notes:   All timing is counted in 16x baud ticks from the divider.
`default_nettype none

package uhst_pkg;

    // ------------------------------------------------------------------
    // Baud clock
    // ------------------------------------------------------------------
    localparam int unsigned OVERSAMPLE      = 16;
    localparam logic [3:0]  TICK_LAST       = 4'hF;
    localparam logic [3:0]  TICK_MID        = 4'h7;
    localparam logic [15:0] DIVISOR_DEFAULT = 16'h0001;

    // ------------------------------------------------------------------
    // Character format
    // ------------------------------------------------------------------
    localparam int unsigned DATA_BITS = 8;
    localparam logic [2:0]  BIT_LAST  = 3'h7;

    // ------------------------------------------------------------------
    // Transmit start delay after the empty interrupt is cleared
    // ------------------------------------------------------------------
    localparam int unsigned TX_GAP_BITS  = 8;
    localparam logic [7:0]  TX_GAP_TICKS = 8'(TX_GAP_BITS * OVERSAMPLE - 1);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic       LINE_IDLE  = 1'b1;

    typedef enum logic [1:0] {
        UHST_RX_IDLE,
        UHST_RX_START,
        UHST_RX_DATA,
        UHST_RX_STOP
    } uhst_rx_state_t;

    typedef enum logic [2:0] {
        UHST_TX_IDLE,
        UHST_TX_GAP,
        UHST_TX_START,
        UHST_TX_DATA,
        UHST_TX_STOP
    } uhst_tx_state_t;

endpackage : uhst_pkg

`default_nettype wire

/* File: design/uhst_baud_gen.sv */
// Purpose: Divides the system clock into a one-cycle 16x baud tick.
// Assumes: divisor_i is static while the channel is in use; zero acts as 1.
// Notes:   The tick is an enable pulse, not a clock.
`default_nettype none

module uhst_baud_gen
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Divisor and tick
    input  wire logic [15:0] divisor_i,
    output logic             tick_o
);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb
    begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + 16'h0001;
        if (cnt_d >= divisor_i)
        begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule : uhst_baud_gen

`default_nettype wire

/* File: verif/uhst_channel_sva.sv */
// Purpose: Port-level timing checks for one UART channel.
// Assumes: baud_divisor_i is static and equals DIV; first data bit sent is 1.
// Notes:   Successive received bytes differ, so a load shows as a change.
`default_nettype none

module uhst_channel_sva
#(
    parameter int DIV = 2
)
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Mode and host strobes
    input  wire logic       fifo_mode_i,
    input  wire logic       host_read_strobe_n_i,
    input  wire logic       host_write_strobe_n_i,
    // Outputs and serial line
    input  wire logic [7:0] rx_holding_reg_o,
    input  wire logic       rx_ready_out_o,
    input  wire logic       tx_ready_out_o,
    input  wire logic       irq_o,
    input  wire logic       rx_i,
    input  wire logic       tx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CLKS = 16 * DIV;
    localparam int BIT_M1   = BIT_CLKS - 1;
    localparam int TICK_WIN = DIV + 1;
    localparam int GAP_MIN  = 8 * BIT_CLKS - 2 * DIV;
    localparam int GAP_MAX  = 24 * BIT_CLKS;

    logic        irq_q;
    logic [15:0] gap_q;
    logic [15:0] gap_d;

    // Saturates so a long idle spell cannot wrap into the legal window.
    always_comb
    begin
        gap_d = (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
        if (irq_q && !irq_o)
            gap_d = 16'h0000;
    end

    always_ff @(posedge clk_i)
    begin
        irq_q <= rst_n_i ? irq_o : 1'b0;
        gap_q <= rst_n_i ? gap_d : 16'hFFFF;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_start_bit; $fell(tx_o) && $past(tx_ready_out_o); endsequence
    sequence s_first_bit; ##BIT_M1 !tx_o ##1 tx_o; endsequence

    property p_rdy_stop; $rose(rx_ready_out_o) |-> $past(rx_i, 3); endproperty
    a_rdy_stop: assert property (p_rdy_stop)
        else $error("receive ready without stop level");
    property p_rx_irq; $rose(rx_ready_out_o) |-> irq_o; endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("receive interrupt late");
    property p_fifo_data;
        $rose(rx_ready_out_o) && fifo_mode_i |-> $changed(rx_holding_reg_o);
    endproperty
    a_fifo_data: assert property (p_fifo_data)
        else $error("fifo data not loaded with status");
    property p_byte_data;
        $rose(rx_ready_out_o) && !fifo_mode_i
            |-> ##[0:TICK_WIN] $changed(rx_holding_reg_o);
    endproperty
    a_byte_data: assert property (p_byte_data)
        else $error("single-byte data later than one tick");
    property p_tx_ready_out_drop; s_start_bit |-> ##[0:BIT_M1] !tx_ready_out_o;
    endproperty
    a_tx_ready_out_drop: assert property (p_tx_ready_out_drop)
        else $error("transmit ready stayed high");
    property p_start_gap;
        s_start_bit |-> gap_q >= GAP_MIN && gap_q <= GAP_MAX;
    endproperty
    a_start_gap: assert property (p_start_gap)
        else $error("start bit outside gap window");
    property p_bit_len; s_start_bit |-> s_first_bit; endproperty
    a_bit_len: assert property (p_bit_len)
        else $error("start bit length wrong");
    property p_read_clr;
        rx_ready_out_o && $fell(host_read_strobe_n_i)
            |-> ##[1:6] !rx_ready_out_o;
    endproperty
    a_read_clr: assert property (p_read_clr)
        else $error("read did not clear receive ready");
    property p_write_clr;
        irq_o && tx_ready_out_o && !rx_ready_out_o
            && $rose(host_write_strobe_n_i) |-> ##[1:6] !irq_o;
    endproperty
    a_write_clr: assert property (p_write_clr)
        else $error("write did not clear empty interrupt");
endmodule : uhst_channel_sva

`default_nettype wire

/* File: verif/uhst_host_model.sv */
// Purpose: Host processor and remote transmitter driving the channel.
// Assumes: All drives change just after a falling clock edge.
// Notes:   Write data is inverted once its hold time has run out.
`default_nettype none

module uhst_host_model
#(
    parameter int DIV = 2
)
(
    // Clock
    input  wire logic      clk_i,
    // Host strobes and data
    output var logic       rd_n_o,
    output var logic       wr_n_o,
    output var logic [7:0] wdata_o,
    // Serial line into the channel
    output var logic       ser_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rd_n_o  = 1'b1;
        wr_n_o  = 1'b1;
        wdata_o = 8'h00;
        ser_o   = 1'b1;
    end

    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_i);
            ser_o = frame[i];
            repeat (16 * DIV - 1) @(negedge clk_i);
        end
        @(negedge clk_i);
        ser_o = 1'b1;
    endtask : send_byte

    task automatic host_read();
        repeat (DIV + 1) @(negedge clk_i);
        rd_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        rd_n_o = 1'b1;
    endtask : host_read

    task automatic host_write(input logic [7:0] d);
        @(negedge clk_i);
        wdata_o = d;
        wr_n_o  = 1'b0;
        repeat (4) @(negedge clk_i);
        wr_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        wdata_o = ~d;
    endtask : host_write
endmodule : uhst_host_model

`default_nettype wire

/* File: verif/tb_uart_host_status_timing.sv */
// Purpose: Self-checking bench for the channel status timing.
// Assumes: Divisor 2, so one bit lasts 32 clocks.
// Notes:   Scenarios run in sequence; a cycle ceiling cuts hangs short.
`default_nettype none

module tb_uart_host_status_timing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV  = 2;
    localparam int BITC = 16 * DIV;

    logic       clk_i, rst_n_i, fifo_mode_i, rd_n, wr_n, ser;
    logic       rx_rdy, tx_rdy, irq, tx;
    logic [7:0] wdata, rx_hold;
    int         bad_count, compares, cyc;

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    uhst_channel uut (.clk_i, .rst_n_i, .fifo_mode_i,
        .baud_divisor_i(16'h0002), .host_read_strobe_n_i(rd_n),
        .host_write_strobe_n_i(wr_n), .host_wdata_i(wdata),
        .rx_holding_reg_o(rx_hold), .rx_ready_out_o(rx_rdy),
        .tx_ready_out_o(tx_rdy), .irq_o(irq), .rx_i(ser), .tx_o(tx));
    uhst_host_model #(.DIV(DIV)) u_host (.clk_i, .rd_n_o(rd_n),
        .wr_n_o(wr_n), .wdata_o(wdata), .ser_o(ser));

    task automatic test_done();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic t_rx(input logic [7:0] b, input logic fm);
        int n;
        fifo_mode_i = fm;
        n = 0;
        fork
            u_host.send_byte(b, 1'b1);
            while (rx_rdy !== 1'b1 && n < 1000)
            begin
                @(negedge clk_i);
                n++;
            end
        join_any
        chk({7'h00, irq}, 8'h01);
        if (fm)
            chk(rx_hold, b);
        repeat (DIV + 1) @(negedge clk_i);
        chk(rx_hold, b);
        wait fork;
        u_host.host_read();
        chk({7'h00, rx_rdy}, 8'h00);
    endtask : t_rx

    task automatic t_tx(input logic [7:0] b);
        logic [7:0] got;
        int         n;
        logic       in_win;
        u_host.host_write(b);
        n = 8;
        while (tx !== 1'b0 && n < 2000)
        begin
            @(negedge clk_i);
            n++;
        end
        in_win = n >= 8 * BITC - 2 * DIV && n <= 24 * BITC;
        chk({7'h00, in_win}, 8'h01);
        chk({7'h00, tx_rdy}, 8'h00);
        repeat (BITC / 2) @(negedge clk_i);
        chk({7'h00, tx}, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BITC) @(negedge clk_i);
            got[i] = tx;
        end
        chk(got, b);
        repeat (BITC) @(negedge clk_i);
        chk({7'h00, tx}, 8'h01);
        repeat (BITC) @(negedge clk_i);
        chk({6'h00, tx_rdy, irq}, 8'h03);
    endtask : t_tx

    // The receive flag only shows on the shared interrupt while the
    // holding-empty source is cleared, so a write is slipped in mid-frame.
    // The read waits for the start bit: a second interrupt fall inside the
    // gap would restart the gap measurement in the checker.
    task automatic t_rx_irq(input logic [7:0] b, input logic [7:0] w);
        int n;
        n = 0;
        fork
            u_host.send_byte(b, 1'b1);
            begin
                repeat (80) @(negedge clk_i);
                u_host.host_write(w);
                chk({7'h00, irq}, 8'h00);
                while (rx_rdy !== 1'b1 && n < 1000)
                begin
                    @(negedge clk_i);
                    n++;
                end
                chk({7'h00, irq}, 8'h01);
            end
        join
        while (tx !== 1'b0 && n < 2000)
        begin
            @(negedge clk_i);
            n++;
        end
        chk({7'h00, tx_rdy}, 8'h00);
        u_host.host_read();
        chk({6'h00, rx_rdy, irq}, 8'h01);
        chk(rx_hold, b);
        while (tx_rdy !== 1'b1 && n < 3000)
        begin
            @(negedge clk_i);
            n++;
        end
        chk({7'h00, tx_rdy}, 8'h01);
    endtask : t_rx_irq

    // Frames go back to back, with distinct bytes after the reset 00.
    initial
    begin
        bad_count   = 0;
        compares    = 0;
        rst_n_i     = 1'b0;
        fifo_mode_i = 1'b0;
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(rx_hold, 8'h00);
        chk({4'h0, rx_rdy, tx_rdy, irq, tx}, 8'h07);
        t_tx(8'hA5);
        t_rx(8'h5A, 1'b0);
        t_rx(8'hC3, 1'b1);
        t_rx_irq(8'h3C, 8'h81);
        test_done();
    end

    initial
    begin
        cyc = 0;
        forever
        begin
            @(posedge clk_i);
            cyc++;
            if (cyc == 20000)
            begin
                bad_count++;
                test_done();
            end
        end
    end
endmodule : tb_uart_host_status_timing

bind uhst_channel uhst_channel_sva #(.DIV(2)) u_sva (.clk_i, .rst_n_i,
    .fifo_mode_i, .host_read_strobe_n_i, .host_write_strobe_n_i,
    .rx_holding_reg_o, .rx_ready_out_o, .tx_ready_out_o, .irq_o,
    .rx_i, .tx_o);

`default_nettype wire
